// ---- core/frame_builder.sv ----
`timescale 1ns/1ps
// combinational frame assembly, msb first, left justified in frame
module frame_builder (
   frame_if.builder fb // control and frame data
);
   localparam int rw = frame_pkg::result_width;
   localparam int fm = frame_pkg::frame_max;

   logic [rw-1:0] data_bits;
   logic [fm-1:0] acc;
   logic [frame_pkg::count_width-1:0] len;
   logic [2:0] sel;
   logic [1:0] sup;
   logic [1:0] inp;
   logic par_result;
   logic par_frame;

   // test patterns replace the result when the top select bit is set
   always_comb begin
      sel = fb.ctrl[frame_pkg::data_value_lo +: 3];
      data_bits = fb.result;
      for (int i = 0; i < rw; i++) begin
         case (sel)
            frame_pkg::pattern_zeros: data_bits[i] = 1'b0;
            frame_pkg::pattern_ones: data_bits[i] = 1'b1;
            frame_pkg::pattern_alt1: data_bits[i] = i[0];
            frame_pkg::pattern_alt2: data_bits[i] = i[1];
            default: data_bits[i] = fb.result[i];
         endcase
      end
   end

   // append items in fixed order, shifting the accumulator left
   always_comb begin
      sup = fb.ctrl[frame_pkg::supply_alarm_lo +: 2];
      inp = fb.ctrl[frame_pkg::input_alarm_lo +: 2];
      acc = '0;
      acc[rw-1:0] = data_bits;
      len = 5'(rw);
      par_result = ^data_bits;
      if (fb.ctrl[frame_pkg::addr_include_bit]) begin
         acc = {acc[fm-5:0], fb.device_addr};
         len = len + 5'h4;
      end
      if (fb.ctrl[frame_pkg::range_include_bit]) begin
         acc = {acc[fm-5:0], fb.range_value};
         len = len + 5'h4;
      end
      if (inp[0]) begin // high input flag
         acc = {acc[fm-2:0], fb.alarm_flags[0]};
         len = len + 5'h1;
      end
      if (inp[1]) begin // low input flag
         acc = {acc[fm-2:0], fb.alarm_flags[1]};
         len = len + 5'h1;
      end
      if (sup[0]) begin // high supply flag
         acc = {acc[fm-2:0], fb.alarm_flags[2]};
         len = len + 5'h1;
      end
      if (sup[1]) begin // low supply flag
         acc = {acc[fm-2:0], fb.alarm_flags[3]};
         len = len + 5'h1;
      end
      par_frame = ^acc; // unused upper bits are zero
      if (fb.ctrl[frame_pkg::parity_enable_bit]) begin
         acc = {acc[fm-3:0], par_result, par_result ^ par_frame};
         len = len + 5'h2;
      end
      // left justify so the first bit out is always bit fm-1
      fb.frame = acc << (5'(fm) - len);
      fb.frame_len = len;
   end
endmodule : frame_builder

// ---- core/frame_if.sv ----
`timescale 1ns/1ps
// link between the register side and the frame builder
interface frame_if;
   logic [31:0] ctrl;
   logic [frame_pkg::result_width-1:0] result;
   logic [frame_pkg::addr_width-1:0] device_addr;
   logic [frame_pkg::range_width-1:0] range_value;
   logic [3:0] alarm_flags;
   logic [frame_pkg::frame_max-1:0] frame;
   logic [frame_pkg::count_width-1:0] frame_len;
   modport builder (input ctrl, result, device_addr, range_value,
                    alarm_flags, output frame, frame_len);
   modport owner (output ctrl, result, device_addr, range_value,
                  alarm_flags, input frame, frame_len);
endinterface : frame_if

// ---- core/frame_pkg.sv ----
package frame_pkg;
   // register map
   localparam logic [7:0] ctrl_offset = 8'h10;
   localparam logic [7:0] status_offset = 8'h14;
   localparam logic [31:0] ctrl_write_mask = 32'h0000_7d0f;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;
   // field positions of the control register
   localparam int addr_include_bit = 14;
   localparam int supply_alarm_lo = 12;
   localparam int input_alarm_lo = 10;
   localparam int range_include_bit = 8;
   localparam int parity_enable_bit = 3;
   localparam int data_value_lo = 0;
   // field widths
   localparam int addr_width = 4;
   localparam int range_width = 4;
   localparam int result_width = 14;
   // widest frame: result, address, range, four flags, two parity bits
   localparam int frame_max = 28;
   localparam int count_width = 5;
   // data value selections
   localparam logic [2:0] pattern_zeros = 3'h4;
   localparam logic [2:0] pattern_ones = 3'h5;
   localparam logic [2:0] pattern_alt1 = 3'h6;
   localparam logic [2:0] pattern_alt2 = 3'h7;
endpackage : frame_pkg

// ---- core/output_frame_composer.sv ----
`timescale 1ns/1ps
// Behaviour
// - address-include bit 14 puts the 4-bit device address in the frame
// - bits 13-12 pick which supply alarm flags enter the frame
// - bits 11-10 pick which input alarm flags enter the frame
// - range-include bit 8 adds the 4-bit range value
// - parity-enable bit 3 appends two parity bits at the end
// - first parity bit is even parity over result bits only
// - second parity bit is even parity over the whole frame
// - parity lengthens the frame by exactly two bits
// - data select with top bit clear sends the conversion result
// - select 100b sends all zeros, 101b all ones
// - select 110b alternates single bits, 111b alternates pairs
// - reserved control bits ignore writes and read zero
module output_frame_composer (
   input wire logic pclk, // apb clock, 50 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [13:0] conv_result, // conversion result, same clock
   input wire logic result_valid, // pulse: new result to frame
   input wire logic [3:0] device_addr, // device address value
   input wire logic [3:0] range_value, // input range setting
   input wire logic [3:0] alarm_flags, // in_h, in_l, vdd_h, vdd_l
   input wire logic shift_clk, // host shift clock, from a pin
   input wire logic frame_start_n, // frame select from host, active low
   output logic serial_out_lines, // serial data out
   output logic [31:0] ctrl_view, // registered control register copy
   output logic [27:0] frame_word, // latched frame, left justified
   output logic [4:0] frame_bits // latched frame length in bits
);
   localparam int fm = frame_pkg::frame_max;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [fm-1:0] frame;
      logic [4:0] len;
      logic [fm-1:0] shreg;
      logic [4:0] left;
      logic sdo;
      logic [1:0] clk_sync;
      logic [1:0] cs_sync;
      logic clk_prev;
   } state_type;

   state_type st;
   state_type next_st;
   frame_if link ();

   frame_builder u_builder (
      .fb (link.builder)
   );

   assign link.ctrl = st.ctrl;
   assign link.result = conv_result;
   assign link.device_addr = device_addr;
   assign link.range_value = range_value;
   assign link.alarm_flags = alarm_flags;

   // register decode used by read and write paths
   function automatic logic hit_ctrl(input logic [7:0] a);
      hit_ctrl = (a == frame_pkg::ctrl_offset);
   endfunction : hit_ctrl

   function automatic logic hit_status(input logic [7:0] a);
      hit_status = (a == frame_pkg::status_offset);
   endfunction : hit_status

   logic setup;
   logic clk_rise;
   logic cs_active;

   // answer is registered from setup, so pready stands in the first access
   // cycle; the master must still wait for it rather than count cycles
   always_comb begin
      next_st = st;
      setup = psel && !penable;
      clk_rise = st.clk_sync[1] && !st.clk_prev;
      cs_active = !st.cs_sync[1];
      next_st.ready = setup;
      next_st.err = setup && !hit_ctrl(paddr) && !hit_status(paddr);
      next_st.rdata = 32'h0000_0000;
      if (setup && !pwrite) begin
         if (hit_ctrl(paddr)) begin
            next_st.rdata = st.ctrl;
         end else if (hit_status(paddr)) begin
            next_st.rdata = {27'h0, st.len};
         end
      end
      // write takes effect at the edge where pready is seen high
      if (psel && penable && st.ready && pwrite && hit_ctrl(paddr)) begin
         next_st.ctrl = pwdata & frame_pkg::ctrl_write_mask;
      end
      // pin synchronisers; only the second stage feeds any logic
      next_st.clk_sync = {st.clk_sync[0], shift_clk};
      next_st.cs_sync = {st.cs_sync[0], frame_start_n};
      next_st.clk_prev = st.clk_sync[1];
      if (result_valid) begin
         next_st.frame = link.frame;
         next_st.len = link.frame_len;
      end
      // frame shifts out msb first; a frame is len bits long
      if (!cs_active) begin
         next_st.shreg = st.frame;
         next_st.left = st.len;
         next_st.sdo = st.frame[fm-1];
      end else if (clk_rise && st.left != 5'h0) begin
         next_st.shreg = {st.shreg[fm-2:0], 1'b0};
         next_st.left = st.left - 5'h1;
         next_st.sdo = st.shreg[fm-2];
      end
   end

   // all state in one register, reset to constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.ctrl <= frame_pkg::ctrl_reset;
         st.clk_sync <= 2'h0;
         st.cs_sync <= 2'h3;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.err;
   assign serial_out_lines = st.sdo;
   assign ctrl_view = st.ctrl;
   assign frame_word = st.frame;
   assign frame_bits = st.len;

   // reserved bits never become set
   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn)
         (st.ctrl & ~frame_pkg::ctrl_write_mask) == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved control bit set");

   // frame length follows the enables exactly
   property p_len;
      @(posedge pclk) disable iff (!presetn)
         result_valid |=> st.len == 5'(14
            + 4 * $past(st.ctrl[frame_pkg::addr_include_bit])
            + 4 * $past(st.ctrl[frame_pkg::range_include_bit])
            + $countones($past(st.ctrl[13:10]))
            + 2 * $past(st.ctrl[frame_pkg::parity_enable_bit]));
   endproperty
   a_len: assert property (p_len)
      else $error("frame length mismatch");

   // with parity, the whole frame has even parity
   property p_frame_parity;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[frame_pkg::parity_enable_bit]
         |=> ^st.frame == 1'b0;
   endproperty
   a_frame_parity: assert property (p_frame_parity)
      else $error("frame parity odd");

   // all-zero pattern gives zero data bits at the top
   property p_zeros;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[2:0] == frame_pkg::pattern_zeros
         |=> st.frame[fm-1 -: 14] == 14'h0;
   endproperty
   a_zeros: assert property (p_zeros)
      else $error("zero pattern wrong");

   // all-ones pattern
   property p_ones;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[2:0] == frame_pkg::pattern_ones
         |=> st.frame[fm-1 -: 14] == 14'h3fff;
   endproperty
   a_ones: assert property (p_ones)
      else $error("ones pattern wrong");

   // alternating single-bit pattern
   property p_alt;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[2:0] == frame_pkg::pattern_alt1
         |=> st.frame[fm-1 -: 14] == 14'h2aaa;
   endproperty
   a_alt: assert property (p_alt)
      else $error("alternating pattern wrong");

   // real result passes when select msb is clear
   property p_result;
      @(posedge pclk) disable iff (!presetn)
         result_valid && !st.ctrl[2]
         |=> st.frame[fm-1 -: 14] == $past(conv_result);
   endproperty
   a_result: assert property (p_result)
      else $error("result not framed");

   // address follows the result directly
   property p_addr;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[frame_pkg::addr_include_bit]
         |=> st.frame[fm-15 -: 4] == $past(device_addr);
   endproperty
   a_addr: assert property (p_addr)
      else $error("address not after result");

   // alternating pairs pattern
   property p_alt_pairs;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[2:0] == frame_pkg::pattern_alt2
         |=> st.frame[fm-1 -: 14] == 14'h0ccc;
   endproperty
   a_alt_pairs: assert property (p_alt_pairs)
      else $error("pair pattern wrong");

   // range follows the result when the address is left out
   property p_range_direct;
      @(posedge pclk) disable iff (!presetn)
         result_valid && !st.ctrl[frame_pkg::addr_include_bit]
         && st.ctrl[frame_pkg::range_include_bit]
         |=> st.frame[fm-15 -: 4] == $past(range_value);
   endproperty
   a_range_direct: assert property (p_range_direct)
      else $error("range not after result");

   // range comes after the address when both are included
   property p_range_after_addr;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[frame_pkg::addr_include_bit]
         && st.ctrl[frame_pkg::range_include_bit]
         |=> st.frame[fm-19 -: 4] == $past(range_value);
   endproperty
   a_range_after_addr: assert property (p_range_after_addr)
      else $error("range not after address");

   // input flags alone: high flag first, then low flag
   property p_input_flags;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[14:8] == 7'h0c
         |=> st.frame[fm-15 -: 2]
             == {$past(alarm_flags[0]), $past(alarm_flags[1])};
   endproperty
   a_input_flags: assert property (p_input_flags)
      else $error("input flags misplaced");

   // supply flags alone: high flag first, then low flag
   property p_supply_flags;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[14:8] == 7'h30
         |=> st.frame[fm-15 -: 2]
             == {$past(alarm_flags[2]), $past(alarm_flags[3])};
   endproperty
   a_supply_flags: assert property (p_supply_flags)
      else $error("supply flags misplaced");

   // first parity bit covers the data bits only
   property p_result_parity;
      @(posedge pclk) disable iff (!presetn)
         result_valid && st.ctrl[frame_pkg::parity_enable_bit]
         |=> st.frame[fm + 1 - int'(st.len)] == ^st.frame[fm-1 -: 14];
   endproperty
   a_result_parity: assert property (p_result_parity)
      else $error("result parity wrong");

   // bits below the end of the frame stay zero
   property p_pad_zero;
      @(posedge pclk) disable iff (!presetn)
         result_valid |=> (st.frame << st.len) == '0;
   endproperty
   a_pad_zero: assert property (p_pad_zero)
      else $error("bits set past frame end");

   // a write keeps only the writable control bits
   property p_write_masked;
      @(posedge pclk) disable iff (!presetn)
         psel && penable && pready && pwrite
         && paddr == frame_pkg::ctrl_offset
         |=> st.ctrl == ($past(pwdata) & frame_pkg::ctrl_write_mask);
   endproperty
   a_write_masked: assert property (p_write_masked)
      else $error("control write not masked");

   // control only changes on a completed write
   property p_ctrl_hold;
      @(posedge pclk) disable iff (!presetn)
         !(psel && penable && pready && pwrite)
         |=> st.ctrl == $past(st.ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold)
      else $error("control changed without write");

   // pready answers in the first access cycle
   property p_ready_after_setup;
      @(posedge pclk) disable iff (!presetn)
         psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("no ready after setup");

   // pready stands for one cycle only
   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
         pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held too long");

   // an error only comes with the answer
   property p_err_with_ready;
      @(posedge pclk) disable iff (!presetn)
         pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("error without ready");

   // a refused read returns zero
   property p_refused_zero;
      @(posedge pclk) disable iff (!presetn)
         pslverr |-> prdata == 32'h0000_0000;
   endproperty
   a_refused_zero: assert property (p_refused_zero)
      else $error("refused read not zero");

   // status read returns the latched frame length
   property p_status_read;
      @(posedge pclk) disable iff (!presetn)
         psel && !penable && !pwrite && paddr == frame_pkg::status_offset
         |=> prdata == {27'h0, $past(st.len)};
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read wrong");

   // while deselected the first frame bit waits on the line
   property p_shift_idle;
      @(posedge pclk) disable iff (!presetn)
         !cs_active |=> serial_out_lines == $past(st.frame[fm-1]);
   endproperty
   a_shift_idle: assert property (p_shift_idle)
      else $error("first bit not presented");

   // each synchronised clock rise while selected with bits left moves one bit and counts it
   property p_shift_step;
      @(posedge pclk) disable iff (!presetn)
         cs_active && clk_rise && st.left != 5'h0
         |=> st.left == $past(st.left) - 5'h1;
   endproperty
   a_shift_step: assert property (p_shift_step)
      else $error("shift count wrong");
endmodule : output_frame_composer

// ---- test/frame_host_model.sv ----
`timescale 1ns/1ps
// host side: clocks a frame out of the device, msb first
module frame_host_model (
   input wire logic pclk, // pacing clock
   input wire logic sdo, // serial data from the device
   output logic shift_clk, // shift clock, still outside frames
   output logic frame_start_n // frame select, active low
);
   // idle: no frame selected, clock held low
   initial begin
      shift_clk = 1'b0;
      frame_start_n = 1'b1;
   end
   // slow edges leave room for the device's two-flop synchronisers
   task automatic read_frame(input int n, output logic [27:0] bits);
      bits = '0;
      frame_start_n <= 1'b0;
      repeat (8) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         bits[27 - i] = sdo;
         shift_clk <= 1'b1;
         repeat (8) @(posedge pclk);
         shift_clk <= 1'b0;
         repeat (8) @(posedge pclk);
      end
      frame_start_n <= 1'b1;
      @(posedge pclk);
   endtask : read_frame
endmodule : frame_host_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
// self-checking bench for the frame composer
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, result_valid;
   logic pready, pslverr, sdo, shift_clk, frame_start_n, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, ctrl_view, rd;
   logic [13:0] conv_result;
   logic [3:0] device_addr, range_value, alarm_flags;
   logic [27:0] frame_word, got;
   logic [4:0] frame_bits;
   logic [32:0] exp_frame;
   wire logic [32:0] latched_frame = {frame_bits, frame_word};
   int mismatches = 0;
   int compares = 0;
   localparam logic [15:0] field_tbl [9] = '{16'h4000, 16'h0100,
      16'h0400, 16'h0800, 16'h0c00, 16'h1000, 16'h2000, 16'h3000,
      16'h7d00};
   localparam logic [15:0] par_tbl [4] = '{16'h0008, 16'h000d,
      16'h0c0f, 16'h7d08};

   output_frame_composer i_output_frame_composer (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_result(conv_result), .result_valid(result_valid),
      .device_addr(device_addr), .range_value(range_value),
      .alarm_flags(alarm_flags), .shift_clk(shift_clk),
      .frame_start_n(frame_start_n), .serial_out_lines(sdo),
      .ctrl_view(ctrl_view), .frame_word(frame_word),
      .frame_bits(frame_bits));
   frame_host_model i_frame_host_model (.pclk(pclk), .sdo(sdo),
      .shift_clk(shift_clk), .frame_start_n(frame_start_n));

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic check(input logic [35:0] seen, input logic [35:0] want);
      compares++;
      if (seen !== want) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check

   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   // one apb transfer, request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no timeout here; if pready never rises, only the watchdog ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // expected frame: length above, bits left justified below
   function automatic logic [32:0] want_frame(logic [31:0] c,
                                              logic [13:0] r);
      logic [27:0] f;
      logic [13:0] d;
      int n;
      case (c[2:0])
         3'h4: d = 14'h0000;
         3'h5: d = 14'h3fff;
         3'h6: d = 14'h2aaa;
         3'h7: d = 14'h0ccc;
         default: d = r;
      endcase
      f = 28'(d);
      n = 14;
      if (c[14]) begin
         f = {f[23:0], device_addr};
         n += 4;
      end
      if (c[8]) begin
         f = {f[23:0], range_value};
         n += 4;
      end
      for (int i = 0; i < 4; i++) begin
         if (c[10 + i]) begin
            f = {f[26:0], alarm_flags[i]};
            n++;
         end
      end
      if (c[3]) begin
         f = {f[26:0], ^d};
         f = {f[26:0], ^f};
         n += 2;
      end
      return {5'(n), f << (28 - n)};
   endfunction : want_frame

   // program control, latch one result, let the frame register land
   task automatic run_frame(input logic [31:0] c, input logic [13:0] r);
      apb(1'b1, 8'h10, c);
      exp_frame = want_frame(c, r);
      @(posedge pclk);
      conv_result <= r;
      result_valid <= 1'b1;
      @(posedge pclk);
      result_valid <= 1'b0;
      @(posedge pclk);
   endtask : run_frame

   task automatic t_regs();
      apb(1'b0, 8'h10, 32'h0);
      check(36'(rd), 36'h0);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      apb(1'b0, 8'h10, 32'h0);
      check(36'(rd), 36'h7d0f);
      check(36'(ctrl_view), 36'h7d0f);
      apb(1'b0, 8'h20, 32'h0);
      check(36'({err, rd}), 36'h1_0000_0000);
      $display("test regs done");
   endtask : t_regs

   task automatic t_patterns();
      for (int s = 0; s < 8; s++) begin
         run_frame(32'(s), 14'h1b5e);
         check(36'(latched_frame), 36'(exp_frame));
      end
      $display("test patterns done");
   endtask : t_patterns

   task automatic t_fields();
      for (int k = 0; k < 18; k++) begin
         alarm_flags <= k[0] ? 4'h9 : 4'h6;
         run_frame(32'(field_tbl[k / 2]), 14'h2c31);
         check(36'(latched_frame), 36'(exp_frame));
      end
      $display("test fields done");
   endtask : t_fields

   task automatic t_parity();
      for (int k = 0; k < 4; k++) begin
         run_frame(32'(par_tbl[k]), 14'h3a50 + 14'(k));
         check(36'(latched_frame), 36'(exp_frame));
      end
      $display("test parity done");
   endtask : t_parity

   // reset in mid-run clears control and the latched frame
   task automatic t_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(36'(ctrl_view), 36'h0);
      check(36'(latched_frame), 36'h0);
      $display("test reset done");
   endtask : t_reset

   // host clocks whole frames out: longest one, then a short one
   task automatic t_serial();
      run_frame(32'h7d0f, 14'h1234);
      i_frame_host_model.read_frame(28, got);
      check(36'(got), 36'(exp_frame[27:0]));
      apb(1'b0, 8'h14, 32'h0);
      check(36'(rd), 36'(exp_frame[32:28]));
      run_frame(32'h4000, 14'h0abc);
      i_frame_host_model.read_frame(18, got);
      check(36'(got), 36'(exp_frame[27:0]));
      $display("test serial done");
   endtask : t_serial

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, result_valid} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_result = 14'h0;
      device_addr = 4'ha;
      range_value = 4'h5;
      alarm_flags = 4'h6;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_patterns();
      t_fields();
      t_parity();
      t_reset();
      t_serial();
      print_verdict();
   end

   // watchdog: the tests need about a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      print_verdict();
   end
endmodule : tb_top
